// File: verilog/elc_ext_line_ctrl.sv
// Notes on behaviour
// - Per-line edge detector: rising, falling, both
// - Detected edge sets pending, raises enabled interrupt
// - Writing one clears pending; zero keeps it
// - Writing zero to edge select clears pending
// - Enabled event pulses on matching edge
// - Software trigger acts like a hardware edge
// - Events wake event-wait, interrupts wake interrupt-wait
// - Lines 0-15 from pins via source select
// - Line 16 supply detector, 17 watchdog
// - Merged vectors: 1:0, 3:2, 15:4, 16, 17
// - Interrupt enable bits; upper bits read zero
// - Event enable bits gate event outputs
// - Ten registers 0x00-0x24 (six at 0x00-0x14, four source selects at 0x18-0x24), reset zero
// - Rising select one enables rising triggers
// - Falling select one enables falling triggers
// - Software trigger one sets pending flag
module elc_ext_line_ctrl (
  // Clock and reset
  input  wire logic                                core_clk_i,
  input  wire logic                                sys_rst_i,
  // Register bus
  input  wire elc_pkg::elc_wb_req_t                wb_req_i,
  output elc_pkg::elc_wb_rsp_t                     wb_rsp_o,
  // Trigger sources
  input  wire logic [elc_pkg::PIN_LINES-1:0]       port_a_pins_i,
  input  wire logic [elc_pkg::PIN_LINES-1:0]       port_b_pins_i,
  input  wire logic                                supply_voltage_detector_i,
  input  wire logic                                independent_watchdog_i,
  // Interrupt vectors toward the nested vector controller
  output logic                                     irq_lines_1_0_o,
  output logic                                     irq_lines_3_2_o,
  output logic                                     irq_lines_15_4_o,
  output logic                                     irq_supply_o,
  output logic                                     irq_watchdog_o,
  output logic                                     ext_line_irq_o,
  // Events and wake-up
  output logic [elc_pkg::NUM_LINES-1:0]            event_o,
  output logic                                     wake_event_o,
  output logic                                     wake_irq_o
);

  localparam int NL = elc_pkg::NUM_LINES;

  elc_pkg::elc_state_t st_reg;       // Registered state
  elc_pkg::elc_state_t st_next;      // Next state
  logic [NL-1:0]       line_raw;     // Selected source per line
  logic [NL-1:0]       rise_hit;     // Rising edge with rising select
  logic [NL-1:0]       fall_hit;     // Falling edge with falling select
  logic [NL-1:0]       trig;         // Hardware or software trigger
  logic [NL-1:0]       sw_pulse;     // Software trigger newly set
  logic [NL-1:0]       clr_w1c;      // Pending bits written with one
  logic [NL-1:0]       clr_sel;      // Pending bits cleared by select write
  logic [NL-1:0]       irq_lines;    // Pending and enabled
  logic [NL-1:0]       w1c_only;     // Cleared by one, no new trigger
  logic [NL-1:0]       sel_only;     // Cleared by select, no new trigger
  logic                bus_hit;      // Request taken this cycle

  // Byte-lane write merge, used for every register except pending
  function automatic logic [31:0] merge_w(input logic [31:0] old_v,
                                          input logic [31:0] wr_v,
                                          input logic [3:0]  sel_v);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel_v[b]) begin
        res[8*b +: 8] = wr_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Byte-lane mask, so that an unselected lane writes no zeros
  function automatic logic [31:0] lane_mask(input logic [3:0] sel_v);
    logic [31:0] res;
    res = 32'h00000000;
    for (int b = 0; b < 4; b++) begin
      res[8*b +: 8] = {8{sel_v[b]}};
    end
    return res;
  endfunction

  // Source-select decode: hit and register index
  function automatic logic src_hit(input logic [elc_pkg::ADR_W-1:0] a);
    return (a >= elc_pkg::OFS_SRC_SEL0) &&
           (a <  elc_pkg::OFS_SRC_SEL0 + 8'(4 * elc_pkg::SRC_REGS));
  endfunction

  function automatic logic [1:0] src_idx(input logic [elc_pkg::ADR_W-1:0] a);
    logic [elc_pkg::ADR_W-1:0] d;
    d = a - elc_pkg::OFS_SRC_SEL0;
    return d[3:2];
  endfunction

  // Source muxing for pin lines; field n%4 of register n/4
  for (genvar n = 0; n < elc_pkg::PIN_LINES; n++) begin : g_src
    assign line_raw[n] =
      (st_reg.src_sel[n / elc_pkg::SRC_PER_REG]
        [(n % elc_pkg::SRC_PER_REG) * elc_pkg::SRC_FIELD_W +: elc_pkg::SRC_FIELD_W]
        == elc_pkg::SRC_PORT_B) ? port_b_pins_i[n] : port_a_pins_i[n];
  end

  // Internal sources on the two upper lines
  assign line_raw[elc_pkg::LINE_SUPPLY] = supply_voltage_detector_i;
  assign line_raw[elc_pkg::LINE_WDOG]   = independent_watchdog_i;

  // Next-state logic for bus, registers and lines
  always_comb begin
    logic [31:0]               wmask;
    logic [31:0]               wdat;
    logic [31:0]               rd;
    logic [31:0]               merged;
    logic [elc_pkg::ADR_W-1:0] adr;
    wmask    = lane_mask(wb_req_i.sel);
    wdat     = wb_req_i.dat;
    rd       = 32'h00000000;
    merged   = 32'h00000000;
    adr      = {wb_req_i.adr[elc_pkg::ADR_W-1:2], 2'b00};
    st_next  = st_reg;
    clr_w1c  = '0;
    clr_sel  = '0;
    sw_pulse = '0;

    // Synchroniser, then a third stage for edge history
    st_next.sync1 = line_raw;
    st_next.sync2 = st_reg.sync1;
    st_next.prev  = st_reg.sync2;

    // Edge detection, selected per line and per direction
    rise_hit = st_reg.sync2 & ~st_reg.prev & st_reg.rise_sel;
    fall_hit = ~st_reg.sync2 & st_reg.prev & st_reg.fall_sel;

    // One request per access; the ack cycle blocks a repeat
    bus_hit = wb_req_i.cyc && wb_req_i.stb &&
              (st_reg.bus_st == elc_pkg::ELC_BUS_IDLE);

    // Register writes
    if (bus_hit && wb_req_i.we) begin
      if (adr == elc_pkg::OFS_IRQ_EN) begin
        merged         = merge_w(32'(st_reg.irq_en), wdat, wb_req_i.sel);
        st_next.irq_en = merged[NL-1:0];
      end else if (adr == elc_pkg::OFS_EVT_EN) begin
        merged         = merge_w(32'(st_reg.evt_en), wdat, wb_req_i.sel);
        st_next.evt_en = merged[NL-1:0];
      end else if (adr == elc_pkg::OFS_RISE_SEL) begin
        merged           = merge_w(32'(st_reg.rise_sel), wdat, wb_req_i.sel);
        st_next.rise_sel = merged[NL-1:0];
        clr_sel          = wmask[NL-1:0] & ~wdat[NL-1:0];
      end else if (adr == elc_pkg::OFS_FALL_SEL) begin
        merged           = merge_w(32'(st_reg.fall_sel), wdat, wb_req_i.sel);
        st_next.fall_sel = merged[NL-1:0];
        clr_sel          = wmask[NL-1:0] & ~wdat[NL-1:0];
      end else if (adr == elc_pkg::OFS_SOFT_TRG) begin
        merged           = merge_w(32'(st_reg.soft_trg), wdat, wb_req_i.sel);
        st_next.soft_trg = merged[NL-1:0];
        // Only a zero-to-one change fires, so rewriting a one is harmless
        sw_pulse         = merged[NL-1:0] & ~st_reg.soft_trg;
      end else if (adr == elc_pkg::OFS_PENDING) begin
        clr_w1c = wmask[NL-1:0] & wdat[NL-1:0];
      end else if (src_hit(adr)) begin
        merged = merge_w(32'(st_reg.src_sel[src_idx(adr)]), wdat, wb_req_i.sel);
        st_next.src_sel[src_idx(adr)] = merged[15:0];
      end else begin
        // Unmapped write is acknowledged and dropped
        merged = 32'h00000000;
      end
    end

    // Software trigger bit drops once its pending flag is written with one
    st_next.soft_trg = st_next.soft_trg & ~clr_w1c;

    // Any trigger; a new set beats a clear in the same cycle
    trig            = rise_hit | fall_hit | sw_pulse;
    st_next.pending = (st_reg.pending & ~(clr_w1c | clr_sel)) | trig;
    w1c_only        = clr_w1c & ~trig;
    sel_only        = clr_sel & ~trig;

    // Event pulse lasts exactly one cycle per trigger
    st_next.event_p = trig & st_reg.evt_en;

    // Read decode; bits above the implemented width read zero
    if (adr == elc_pkg::OFS_IRQ_EN) begin
      rd = 32'(st_reg.irq_en);
    end else if (adr == elc_pkg::OFS_EVT_EN) begin
      rd = 32'(st_reg.evt_en);
    end else if (adr == elc_pkg::OFS_RISE_SEL) begin
      rd = 32'(st_reg.rise_sel);
    end else if (adr == elc_pkg::OFS_FALL_SEL) begin
      rd = 32'(st_reg.fall_sel);
    end else if (adr == elc_pkg::OFS_SOFT_TRG) begin
      rd = 32'(st_reg.soft_trg);
    end else if (adr == elc_pkg::OFS_PENDING) begin
      rd = 32'(st_reg.pending);
    end else if (src_hit(adr)) begin
      rd = 32'(st_reg.src_sel[src_idx(adr)]);
    end else begin
      rd = 32'h00000000;  // Unmapped reads zero
    end

    // Bus slave: answer one cycle after the request is taken
    case (st_reg.bus_st)
      elc_pkg::ELC_BUS_IDLE: begin
        if (bus_hit) begin
          st_next.bus_st = elc_pkg::ELC_BUS_ACK;
          st_next.rdata  = wb_req_i.we ? elc_pkg::DATA_RST : rd;
        end
      end
      elc_pkg::ELC_BUS_ACK: begin
        // Drop ack for one cycle so a held request is not taken twice
        st_next.bus_st = elc_pkg::ELC_BUS_IDLE;
      end
      default: begin
        st_next.bus_st = elc_pkg::ELC_BUS_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_reg <= elc_pkg::STATE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Interrupt level follows pending and enable; software must clear it
  assign irq_lines        = st_reg.pending & st_reg.irq_en;
  assign irq_lines_1_0_o  = |irq_lines[1:0];
  assign irq_lines_3_2_o  = |irq_lines[3:2];
  assign irq_lines_15_4_o = |irq_lines[15:4];
  assign irq_supply_o     = irq_lines[elc_pkg::LINE_SUPPLY];
  assign irq_watchdog_o   = irq_lines[elc_pkg::LINE_WDOG];
  assign ext_line_irq_o   = |irq_lines;

  // Events and wake-up requests
  assign event_o      = st_reg.event_p;
  assign wake_event_o = |st_reg.event_p;
  assign wake_irq_o   = |irq_lines;

  // Bus answer straight from the state
  assign wb_rsp_o.ack = (st_reg.bus_st == elc_pkg::ELC_BUS_ACK);
  assign wb_rsp_o.dat = st_reg.rdata;

  // Checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  property p_rise_pend;
    (rise_hit != '0) |=> ((st_reg.pending & $past(rise_hit)) == $past(rise_hit));
  endproperty
  a_rise_pend: assert property (p_rise_pend) else $error("rising edge lost");

  property p_fall_pend;
    (fall_hit != '0) |=> ((st_reg.pending & $past(fall_hit)) == $past(fall_hit));
  endproperty
  a_fall_pend: assert property (p_fall_pend) else $error("falling edge lost");

  property p_irq_raise;
    ((trig & st_reg.irq_en) != '0) |=> ext_line_irq_o;
  endproperty
  a_irq_raise: assert property (p_irq_raise) else $error("no interrupt");

  property p_w1c;
    (w1c_only != '0) |=> ((st_reg.pending & $past(w1c_only)) == '0);
  endproperty
  a_w1c: assert property (p_w1c) else $error("pending not cleared");

  property p_sel_clr;
    (sel_only != '0) |=> ((st_reg.pending & $past(sel_only)) == '0);
  endproperty
  a_sel_clr: assert property (p_sel_clr) else $error("select write kept pending");

  property p_event_cause;
    (event_o != '0) |-> (($past(trig) & event_o) == event_o);
  endproperty
  a_event_cause: assert property (p_event_cause) else $error("event without trigger");

  property p_soft_pend;
    (sw_pulse != '0) |=> ((st_reg.pending & $past(sw_pulse)) == $past(sw_pulse));
  endproperty
  a_soft_pend: assert property (p_soft_pend) else $error("soft trigger lost");

  property p_wake_evt;
    ((trig & st_reg.evt_en) != '0) |=> wake_event_o ##1 (!wake_event_o || ($past(trig) != '0));
  endproperty
  a_wake_evt: assert property (p_wake_evt) else $error("wake event missing");

  property p_sync_delay;
    (st_reg.sync2 != st_reg.prev) |-> ($past(line_raw, 2) != $past(line_raw, 3));
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("sync depth wrong");

  property p_upper_zero;
    wb_rsp_o.ack |-> (wb_rsp_o.dat[31:NL] == '0);
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper bits not zero");

  property p_bus_ack;
    bus_hit |=> wb_rsp_o.ack ##1 !wb_rsp_o.ack;
  endproperty
  a_bus_ack: assert property (p_bus_ack) else $error("ack timing wrong");

  c_soft_trig: cover property (sw_pulse != '0 ##1 ext_line_irq_o);
  c_rise_evt:  cover property (rise_hit != '0 ##1 event_o != '0);
  c_w1c:       cover property (ext_line_irq_o ##1 w1c_only != '0 ##1 !ext_line_irq_o);
  c_fall:      cover property (fall_hit != '0);

endmodule

// File: verilog/elc_pkg.sv
package elc_pkg;

  // Sizes
  localparam int NUM_LINES     = 18;           // Trigger lines in use
  localparam int PIN_LINES     = 16;           // Lines fed from port pins
  localparam int SRC_REGS      = 4;            // Source-select registers
  localparam int SRC_PER_REG   = 4;            // Lines per source-select register
  localparam int SRC_FIELD_W   = 4;            // Bits per source-select field
  localparam int ADR_W         = 8;            // Decoded byte-address bits
  localparam int LINE_SUPPLY   = 16;           // Supply-voltage detector line
  localparam int LINE_WDOG     = 17;           // Independent watchdog line

  // Register byte offsets
  localparam logic [ADR_W-1:0] OFS_IRQ_EN   = 8'h00;
  localparam logic [ADR_W-1:0] OFS_EVT_EN   = 8'h04;
  localparam logic [ADR_W-1:0] OFS_RISE_SEL = 8'h08;
  localparam logic [ADR_W-1:0] OFS_FALL_SEL = 8'h0C;
  localparam logic [ADR_W-1:0] OFS_SOFT_TRG = 8'h10;
  localparam logic [ADR_W-1:0] OFS_PENDING  = 8'h14;
  localparam logic [ADR_W-1:0] OFS_SRC_SEL0 = 8'h18;   // Then 0x1C, 0x20, 0x24

  // Field values and reset values
  localparam logic [SRC_FIELD_W-1:0] SRC_PORT_B = 4'h1; // Any other code selects port A
  localparam logic [NUM_LINES-1:0]   LINE_RST   = 18'h00000;
  localparam logic [15:0]            SRC_RST    = 16'h0000;
  localparam logic [31:0]            DATA_RST   = 32'h00000000;

  // Bus slave states, one-hot
  typedef enum logic [1:0] {
    ELC_BUS_IDLE = 2'b01,
    ELC_BUS_ACK  = 2'b10
  } elc_bus_st_t;

  // Classic Wishbone request from the master
  typedef struct packed {
    logic             cyc;
    logic             stb;
    logic             we;
    logic [ADR_W-1:0] adr;
    logic [3:0]       sel;
    logic [31:0]      dat;
  } elc_wb_req_t;

  // Classic Wishbone answer to the master
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } elc_wb_rsp_t;

  // Whole state of the controller
  typedef struct packed {
    elc_bus_st_t                bus_st;
    logic [31:0]                rdata;
    logic [NUM_LINES-1:0]       irq_en;
    logic [NUM_LINES-1:0]       evt_en;
    logic [NUM_LINES-1:0]       rise_sel;
    logic [NUM_LINES-1:0]       fall_sel;
    logic [NUM_LINES-1:0]       soft_trg;
    logic [NUM_LINES-1:0]       pending;
    logic [NUM_LINES-1:0]       sync1;
    logic [NUM_LINES-1:0]       sync2;
    logic [NUM_LINES-1:0]       prev;
    logic [NUM_LINES-1:0]       event_p;
    logic [SRC_REGS-1:0][15:0]  src_sel;
  } elc_state_t;

  localparam elc_state_t STATE_RST = '{
    bus_st:   ELC_BUS_IDLE,
    rdata:    DATA_RST,
    irq_en:   LINE_RST,
    evt_en:   LINE_RST,
    rise_sel: LINE_RST,
    fall_sel: LINE_RST,
    soft_trg: LINE_RST,
    pending:  LINE_RST,
    sync1:    LINE_RST,
    sync2:    LINE_RST,
    prev:     LINE_RST,
    event_p:  LINE_RST,
    src_sel:  {SRC_RST, SRC_RST, SRC_RST, SRC_RST}
  };

endpackage

// File: sim/elc_core_model.sv
module elc_core_model (
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic sys_rst_i,
  // Wake requests from the line controller
  input  wire logic wake_event_i,
  input  wire logic wake_irq_i,
  // Wake tallies for the bench
  output int        evt_wakes_o,
  output int        irq_wakes_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic irq_q;  // Last interrupt level seen
  // Core leaves event-wait per pulse, interrupt-wait per new level;
  // it never clears pending itself, the bench software does that
  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      evt_wakes_o <= 0;
      irq_wakes_o <= 0;
      irq_q       <= 1'b0;
    end else begin
      evt_wakes_o <= evt_wakes_o + int'(wake_event_i === 1'b1);
      irq_wakes_o <= irq_wakes_o + int'(wake_irq_i & ~irq_q);
      irq_q       <= wake_irq_i;
    end
  end
endmodule

// File: sim/elc_ext_line_ctrl_tb_top.sv
module elc_ext_line_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // Clock, reset, bus
  logic                 core_clk;
  logic                 sys_rst;
  elc_pkg::elc_wb_req_t wb_req;
  elc_pkg::elc_wb_rsp_t wb_rsp;
  // Trigger sources
  logic [15:0]          pins_a;
  logic [15:0]          pins_b;
  logic                 supply;
  logic                 wdog;
  // Vectors: watchdog, supply, 15_4, 3_2, 1_0
  wire  [4:0]           vec;
  logic                 ext_irq;
  logic                 wake_irq;
  logic                 wake_evt;
  logic [17:0]          evt;
  // Bench state
  int                   evt_wakes;
  int                   irq_wakes;
  int                   evt_seen [18];
  int                   err_count;
  int                   compares;
  logic [31:0]          rd;
  logic                 ack_s;      // Bus answer sampled mid-cycle
  logic [31:0]          dat_s;      // Read data sampled mid-cycle
  int                   lines [7] = '{0, 1, 3, 4, 15, 16, 17};
  int                   grp [7]   = '{0, 0, 1, 2, 2, 3, 4};

  elc_ext_line_ctrl elc_ext_line_ctrl_i (
    .core_clk_i(core_clk), .sys_rst_i(sys_rst),
    .wb_req_i(wb_req), .wb_rsp_o(wb_rsp),
    .port_a_pins_i(pins_a), .port_b_pins_i(pins_b),
    .supply_voltage_detector_i(supply), .independent_watchdog_i(wdog),
    .irq_lines_1_0_o(vec[0]), .irq_lines_3_2_o(vec[1]),
    .irq_lines_15_4_o(vec[2]), .irq_supply_o(vec[3]),
    .irq_watchdog_o(vec[4]), .ext_line_irq_o(ext_irq),
    .event_o(evt), .wake_event_o(wake_evt), .wake_irq_o(wake_irq)
  );

  elc_core_model elc_core_model_i (
    .core_clk_i(core_clk), .sys_rst_i(sys_rst),
    .wake_event_i(wake_evt), .wake_irq_i(wake_irq),
    .evt_wakes_o(evt_wakes), .irq_wakes_o(irq_wakes)
  );

  // Free-running 20 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // Bus answer settles mid-cycle; reading it on the rising edge would race the registers
  always @(negedge core_clk) begin
    ack_s = wb_rsp.ack;
    dat_s = wb_rsp.dat;
  end

  // Pulses last one cycle; tally them mid-cycle, away from the launching edge
  always @(negedge core_clk) begin
    for (int i = 0; i < elc_pkg::NUM_LINES; i++) begin
      evt_seen[i] += int'(evt[i] === 1'b1);
    end
  end

  // Register and output comparisons
  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic cmp_irq(input logic [4:0] exp);
    compares++;
    if ({wake_irq, ext_irq, vec} !== {|exp, |exp, exp}) begin
      err_count++;
      $display("mismatch at %0t: irq outputs want %h", $time, exp);
    end
  endtask
  task automatic cmp_int(input int got, input int exp, input string what);
    compares++;
    if (got != exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %0d want %0d", $time, what, got, exp);
    end
  endtask

  // One classic cycle; hold until ack is sampled, then release
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
    int guard;
    guard = 0;
    @(posedge core_clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: wd};
    do begin
      @(posedge core_clk);
      guard++;
    end while (ack_s !== 1'b1 && guard < 20);
    rd = dat_s;
    if (guard >= 20) begin
      err_count++;
      $display("mismatch at %0t: no ack", $time);
    end
    wb_req.cyc <= 1'b0;
    wb_req.stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] adr, input logic [31:0] d);
    wb(1'b1, adr, d);
  endtask
  task automatic rdc(input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h00000000);
    cmp32(rd, exp, "read");
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Line n source: pins 0-15, then supply detector, then watchdog
  task automatic drv(input int n, input logic v);
    @(posedge core_clk);
    if (n < 16) begin
      pins_a[n] <= v;
    end else if (n == 16) begin
      supply <= v;
    end else begin
      wdog <= v;
    end
  endtask

  task automatic tally_and_finish();
    $display("Counts: %0d compares, %0d mismatches", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Hang guard, far beyond the expected run length
  initial begin
    wt(6000);
    err_count++;
    $display("mismatch at %0t: run hung", $time);
    tally_and_finish();
  end

  // Main sequence
  initial begin
    sys_rst = 1'b1;
    wb_req = '0;
    {pins_a, pins_b, supply, wdog} = '0;
    wt(12);
    sys_rst <= 1'b0;
    // Reset values, unmapped place, upper bits
    for (int i = 0; i < 6; i++) rdc(8'(i * 4), 32'h00000000);
    wr(8'h40, 32'hFFFFFFFF);
    rdc(8'h40, 32'h00000000);
    for (int i = 0; i < 5; i++) begin
      wr(8'(i * 4), 32'hFFFFFFFF);
      rdc(8'(i * 4), 32'h0003FFFF);
    end
    // All soft triggers fired at once above
    rdc(8'h14, 32'h0003FFFF);
    cmp_irq(5'h1F);
    wr(8'h14, 32'h00000000);
    rdc(8'h14, 32'h0003FFFF);
    wr(8'h14, 32'hFFFFFFFF);
    rdc(8'h14, 32'h00000000);
    rdc(8'h10, 32'h00000000);
    cmp_irq(5'h00);
    for (int i = 0; i < 18; i++) cmp_int(evt_seen[i], 1, "soft event");
    cmp_int(evt_wakes, 1, "event wakes");
    cmp_int(irq_wakes, 1, "irq wakes");
    // Rising edge per group, exact sync latency, falling ignored
    wr(8'h0C, 32'h00000000);
    foreach (lines[j]) begin
      drv(lines[j], 1'b1);
      wt(2);
      #1 cmp_irq(5'h00);
      wt(1);
      #1 cmp_irq(5'h01 << grp[j]);
      rdc(8'h14, 32'h1 << lines[j]);
      wr(8'h14, 32'h1 << lines[j]);
      drv(lines[j], 1'b0);
      wt(5);
      rdc(8'h14, 32'h00000000);
      cmp_int(evt_seen[lines[j]], 2, "edge event");
    end
    // Falling only, then select-zero clearing
    wr(8'h08, 32'h00000000);
    wr(8'h0C, 32'h00000004);
    drv(2, 1'b1);
    wt(5);
    rdc(8'h14, 32'h00000000);
    drv(2, 1'b0);
    wt(5);
    rdc(8'h14, 32'h00000004);
    cmp_irq(5'h02);
    wr(8'h0C, 32'h00000000);
    rdc(8'h14, 32'h00000000);
    // Both edges on line 5
    wr(8'h08, 32'h00000020);
    wr(8'h0C, 32'h00000020);
    drv(5, 1'b1);
    wt(5);
    wr(8'h14, 32'h00000020);
    drv(5, 1'b0);
    wt(5);
    rdc(8'h14, 32'h00000020);
    cmp_int(evt_seen[5], 3, "both edges");
    wr(8'h08, 32'h00000000);
    rdc(8'h14, 32'h00000000);
    // Event without interrupt, then interrupt without event
    wr(8'h00, 32'h00000000);
    wr(8'h04, 32'h00000002);
    wr(8'h08, 32'h00000002);
    drv(1, 1'b1);
    wt(5);
    cmp_irq(5'h00);
    rdc(8'h14, 32'h00000002);
    cmp_int(evt_seen[1], 3, "event only");
    wr(8'h00, 32'h00000002);
    cmp_irq(5'h01);
    wr(8'h14, 32'h00000002);
    cmp_irq(5'h00);
    wr(8'h04, 32'h00000000);
    drv(1, 1'b0);
    drv(1, 1'b1);
    wt(5);
    cmp_int(evt_seen[1], 3, "event masked");
    rdc(8'h14, 32'h00000002);
    wr(8'h14, 32'h00000002);
    // Line 0 moved to port B
    wr(8'h18, 32'h00000001);
    wr(8'h08, 32'h00000001);
    wr(8'h00, 32'h00000001);
    drv(0, 1'b1);
    wt(5);
    rdc(8'h14, 32'h00000000);
    pins_b[0] <= 1'b1;
    wt(5);
    rdc(8'h14, 32'h00000001);
    cmp_irq(5'h01);
    wr(8'h14, 32'h00000001);
    // Soft trigger with no edge selected
    wr(8'h08, 32'h00000000);
    wr(8'h00, 32'h00020000);
    wr(8'h04, 32'h00020000);
    wr(8'h10, 32'h00020000);
    cmp_irq(5'h10);
    rdc(8'h14, 32'h00020000);
    cmp_int(evt_seen[17], 3, "soft event");
    wr(8'h14, 32'h00020000);
    rdc(8'h10, 32'h00000000);
    tally_and_finish();
  end
endmodule
